/* File: dv/idr_host_model.sv */
// Host adapter model that drains the identify block
`timescale 1ns/1ps
module idr_host_model import idr_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic en_i,
  input wire logic [3:0] gap_i,
  input wire idr_status_t status_i,
  input wire logic [15:0] data_i,
  output logic rd_o = 1'b0
);
  logic [15:0] words [256]; // Captured block
  int n_words = 0;
  int wait_cnt = 0;
  // Capture on the taking edge, then move the strobe just after it
  always @(posedge ref_clk_i) begin
    if (rd_o && status_i.data_req) begin
      words[n_words[7:0]] = data_i;
      n_words++;
    end
    #1;
    if (!en_i) n_words = 0;
    if (rd_o && gap_i != 4'h0) begin
      rd_o = 1'b0;
      wait_cnt = gap_i;
    end else if (wait_cnt != 0) wait_cnt--;
    else rd_o = en_i && status_i.data_req;
  end
endmodule : idr_host_model

/* File: dv/idr_responder_properties.sv */
// Port-level assertions of the identify data responder
`timescale 1ns/1ps
module idr_responder_chk import idr_pkg::*; #(
  parameter logic [7:0] SIG_CYL_LO = 8'h00,
  parameter logic [7:0] SIG_CYL_HI = 8'h00
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic packet_dev_i,
  input wire logic int_dis_i,
  input wire logic data_rd_i,
  input wire idr_status_t status_o,
  input wire logic intrq_o,
  input wire logic [15:0] data_o,
  input wire logic [7:0] sig_cyl_lo_o,
  input wire logic [7:0] sig_cyl_hi_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Identify that the device must take
  wire cmd_ok = cmd_valid_i && cmd_code_i == IDR_CMD_IDENTIFY && !status_o.busy
                && !status_o.data_req;
  wire xfer = status_o.data_req;
  // Index of the word now shown, so word checks need no copy of the body
  logic [8:0] idx_r;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) idx_r <= 9'h000;
    else if (!xfer) idx_r <= 9'h000;
    else if (data_rd_i) idx_r <= idx_r + 9'h001;
  end
  property p_start;
    cmd_ok && !packet_dev_i |=> status_o.busy && !xfer;
  endproperty
  a_start: assert property (p_start) else $error("no busy");
  property p_prep;
    $rose(status_o.busy) |-> ##[1:40] (xfer && !status_o.busy);
  endproperty
  a_prep: assert property (p_prep) else $error("no request");
  property p_irq;
    $rose(xfer) && !int_dis_i |-> intrq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
  property p_abort;
    cmd_ok && packet_dev_i |=> status_o.aborted && status_o.error && !xfer
      && sig_cyl_lo_o == SIG_CYL_LO && sig_cyl_hi_o == SIG_CYL_HI;
  endproperty
  a_abort: assert property (p_abort) else $error("bad abort");
  property p_end;
    xfer && data_rd_i && idx_r == 9'h0FF |=> !xfer && !status_o.busy && status_o.ready;
  endproperty
  a_end: assert property (p_end) else $error("phase not ended");
  property p_tag;
    xfer && idx_r == 9'h02F |-> data_o[15:8] == 8'h80;
  endproperty
  a_tag: assert property (p_tag) else $error("bad tag byte");
  property p_caps;
    xfer && idx_r == 9'h031 |-> data_o[9:8] == 2'b11 && data_o[7:0] == 8'h00;
  endproperty
  a_caps: assert property (p_caps) else $error("bad capabilities");
  property p_print;
    xfer && idx_r >= 9'h00A && idx_r <= 9'h013 |-> data_o[15:8] inside {[8'h20:8'h7E]}
      && data_o[7:0] inside {[8'h20:8'h7E]};
  endproperty
  a_print: assert property (p_print) else $error("unprintable byte");
endmodule : idr_responder_chk

bind idr_responder idr_responder_chk #(.SIG_CYL_LO(SIG_CYL_LO), .SIG_CYL_HI(SIG_CYL_HI)) u_chk (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .packet_dev_i(packet_dev_i), .int_dis_i(int_dis_i),
  .data_rd_i(data_rd_i), .status_o(status_o), .intrq_o(intrq_o), .data_o(data_o),
  .sig_cyl_lo_o(sig_cyl_lo_o), .sig_cyl_hi_o(sig_cyl_hi_o));

/* File: dv/idr_responder_tb_top.sv */
// Self-checking bench of the identify data responder
`timescale 1ns/1ps
module idr_responder_tb_top import idr_pkg::*;;
  localparam logic [7:0] SIG_LO = 8'h5A; // Arbitrary value
  localparam logic [7:0] SIG_HI = 8'hC3; // Arbitrary value
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic packet_dev_i = 1'b0;
  logic int_dis_i = 1'b0;
  logic status_rd_i = 1'b0;
  logic host_en = 1'b0;
  logic [3:0] host_gap = 4'h0;
  logic data_rd_i;
  // Serial holds one unprintable byte on purpose
  idr_cfg_t cfg_i = '{1'b1, 1'b0, 1'b1, 16'h3A5C, 16'h0010, 16'h003F,
    {"SN", 8'h01, "34567890ABCDEFGHI"}, "FW1.02AB", {4{"Model_1234"}}, 8'h10,
    1'b1, 1'b1, 1'b0, 3'b101, 16'h1234, 16'h0010, 16'h003F, 32'hCAFE0042};
  idr_status_t status_o;
  logic intrq_o;
  logic [15:0] data_o;
  logic [7:0] sig_lo;
  logic [7:0] sig_hi;
  int n_errors = 0;
  int cmp_count = 0;
  idr_responder #(.SIG_CYL_LO(SIG_LO), .SIG_CYL_HI(SIG_HI)) DUT (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .packet_dev_i(packet_dev_i), .int_dis_i(int_dis_i),
    .status_rd_i(status_rd_i), .data_rd_i(data_rd_i), .cfg_i(cfg_i), .status_o(status_o),
    .intrq_o(intrq_o), .data_o(data_o), .sig_cyl_lo_o(sig_lo), .sig_cyl_hi_o(sig_hi));
  idr_host_model u_host (.ref_clk_i(ref_clk_i), .en_i(host_en), .gap_i(host_gap),
    .status_i(status_o), .data_i(data_o), .rd_o(data_rd_i));
  initial forever #2 ref_clk_i = ~ref_clk_i;
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Unprintable bytes show as a space
  function automatic logic [7:0] pr(input logic [7:0] c);
    return (c >= 8'h20 && c <= 8'h7E) ? c : 8'h20;
  endfunction : pr
  // Expected word with a flag in bit 16 saying it is checked
  function automatic logic [16:0] exp_word(input int i);
    logic [15:0] s;
    s = 16'h0000;
    if (i >= 10 && i <= 19) s = cfg_i.serial[159 - 16 * (i - 10) -: 16];
    if (i >= 23 && i <= 26) s = cfg_i.firmware[63 - 16 * (i - 23) -: 16];
    if (i >= 27 && i <= 46) s = cfg_i.model[319 - 16 * (i - 27) -: 16];
    case (i)
      0: return {9'h100, cfg_i.removable, cfg_i.fixed_dev, 3'h0, cfg_i.resp_incomplete, 2'h0};
      1: return {1'b1, cfg_i.cylinders};
      3: return {1'b1, cfg_i.heads};
      6: return {1'b1, cfg_i.sectors};
      7, 8, 48: return 17'h10000;
      47: return {1'b1, 8'h80, cfg_i.max_multi};
      49: return {3'h4, cfg_i.standby_std, 1'b0, cfg_i.iordy_sup, cfg_i.iordy_dis, 10'h300};
      50: return 17'h14001;
      53: return {14'h2000, cfg_i.valid_flags};
      54: return {1'b1, cfg_i.cur_cylinders};
      55: return {1'b1, cfg_i.cur_heads};
      56: return {1'b1, cfg_i.cur_sectors};
      57: return {1'b1, cfg_i.capacity[15:0]};
      58: return {1'b1, cfg_i.capacity[31:16]};
      default: return {(i >= 10 && i <= 46 && !(i inside {[20:22]})), pr(s[15:8]), pr(s[7:0])};
    endcase
  endfunction : exp_word
  task automatic pulse_cmd(input logic [7:0] code);
    cmd_code_i = code;
    cmd_valid_i = 1'b1;
    tick();
    cmd_valid_i = 1'b0;
    tick();
  endtask : pulse_cmd
  task automatic t_reset;
    check(status_o, IDR_STATUS_RST, "reset status");
    check(intrq_o, 1'b0, "reset interrupt");
    check(data_o, 16'h0000, "reset data");
  endtask : t_reset
  // Other code ignored, then packet device aborts identify
  task automatic t_abort;
    packet_dev_i = 1'b1;
    pulse_cmd(8'hDA);
    check(status_o, IDR_STATUS_RST, "foreign code");
    pulse_cmd(IDR_CMD_IDENTIFY);
    check(status_o, 16'h000B, "abort");
    check({sig_hi, sig_lo}, {SIG_HI, SIG_LO}, "signature");
    check(intrq_o, 1'b1, "abort interrupt");
    packet_dev_i = 1'b0;
  endtask : t_abort
  // Full identify, with a refused command in mid-transfer
  task automatic t_identify(input logic dis, input logic [3:0] gap);
    int k;
    logic [16:0] e;
    logic [15:0] w;
    int_dis_i = dis;
    host_gap = gap;
    host_en = 1'b1;
    pulse_cmd(IDR_CMD_IDENTIFY);
    check({status_o.busy, status_o.error}, 2'h2, "busy on start");
    for (k = 0; k < 100 && status_o.data_req !== 1'b1; k++) tick();
    check({status_o.busy, status_o.data_req, intrq_o}, {2'h1, !dis}, "request");
    pulse_cmd(IDR_CMD_IDENTIFY);
    for (k = 0; k < 2000 && status_o.data_req === 1'b1; k++) tick();
    check(u_host.n_words[15:0], 16'h0100, "word count");
    for (int i = 0; i < 59; i++) begin
      e = exp_word(i);
      w = u_host.words[i];
      if (e[16] && i >= 10 && i <= 46) check(w, e[15:0], "string");
      else if (e[16] && i < 10) check(w, e[15:0], "geometry word");
      else if (e[16] && i < 53) check(w, e[15:0], "flag word");
      else if (e[16]) check(w, e[15:0], "current word");
    end
    check({status_o.busy, status_o.ready, status_o.data_req}, 3'h2, "end status");
    check(data_o, 16'h0000, "end data");
    status_rd_i = 1'b1;
    tick();
    status_rd_i = 1'b0;
    host_en = 1'b0;
    tick();
    check(intrq_o, 1'b0, "interrupt cleared");
  endtask : t_identify
  initial begin
    repeat (5) @(posedge ref_clk_i);
    #1;
    arst_n_i = 1'b1;
    t_reset();
    t_abort();
    t_identify(1'b0, 4'h0);
    t_identify(1'b1, 4'h3);
    finish_test();
  end
  // Hang guard, well beyond two transfers
  initial begin
    #40000;
    n_errors++;
    $display("MISMATCH at %0t: watchdog", $time);
    finish_test();
  end
endmodule : idr_responder_tb_top

/* File: verilog/idr_pkg.sv */
// Shared constants and carrier types of the identify data responder
package idr_pkg;
  // ****************************************
  // Command and transfer sizing
  // ****************************************
  localparam logic [7:0] IDR_CMD_IDENTIFY = 8'hEC; // Identify command code
  localparam int IDR_WORDS = 256; // Parameter block length in words
  localparam logic [8:0] IDR_LAST_WORD = 9'h0FF; // Index of final word
  localparam logic [8:0] IDR_WORD_END = 9'h100; // Fill counter end value
  localparam int IDR_FIFO_DEPTH = 16; // Staging FIFO depth
  localparam int IDR_FIFO_WIDTH = 16; // Staging FIFO width

  // ****************************************
  // Word indices of the parameter block
  // ****************************************
  localparam logic [7:0] IDR_W_CONFIG = 8'h00;
  localparam logic [7:0] IDR_W_CYL = 8'h01;
  localparam logic [7:0] IDR_W_HEADS = 8'h03;
  localparam logic [7:0] IDR_W_SPT = 8'h06;
  localparam logic [7:0] IDR_W_SERIAL = 8'h0A; // Words 10..19
  localparam logic [7:0] IDR_W_SERIAL_END = 8'h13;
  localparam logic [7:0] IDR_W_FW = 8'h17; // Words 23..26
  localparam logic [7:0] IDR_W_FW_END = 8'h1A;
  localparam logic [7:0] IDR_W_MODEL = 8'h1B; // Words 27..46
  localparam logic [7:0] IDR_W_MODEL_END = 8'h2E;
  localparam logic [7:0] IDR_W_MULTI = 8'h2F;
  localparam logic [7:0] IDR_W_CAPS = 8'h31;
  localparam logic [7:0] IDR_W_CAPS2 = 8'h32;
  localparam logic [7:0] IDR_W_VALID = 8'h35;
  localparam logic [7:0] IDR_W_CUR_CYL = 8'h36;
  localparam logic [7:0] IDR_W_CUR_HEADS = 8'h37;
  localparam logic [7:0] IDR_W_CUR_SPT = 8'h38;
  localparam logic [7:0] IDR_W_CAP_LO = 8'h39;
  localparam logic [7:0] IDR_W_CAP_HI = 8'h3A;

  // ****************************************
  // Fixed field values
  // ****************************************
  localparam logic [7:0] IDR_MULTI_TAG = 8'h80; // Upper byte of word 47
  localparam logic [15:0] IDR_CAPS2_VAL = 16'h4001; // Word 50 pattern
  localparam logic [1:0] IDR_CAPS_ONES = 2'h3; // Word 49 bits 9..8
  localparam logic [7:0] IDR_GRAPH_LO = 8'h20; // Lowest printable code
  localparam logic [7:0] IDR_GRAPH_HI = 8'h7E; // Highest printable code
  localparam logic [15:0] IDR_DATA_RST = 16'h0000;

  // Controller states
  typedef enum logic [1:0] {
    IDR_IDLE = 2'b00,
    IDR_PREP = 2'b01,
    IDR_XFER = 2'b10
  } idr_state_t;

  // Device configuration presented to the block
  typedef struct packed {
    logic removable; // Word 0 bit 7
    logic fixed_dev; // Word 0 bit 6
    logic resp_incomplete; // Word 0 bit 2
    logic [15:0] cylinders;
    logic [15:0] heads;
    logic [15:0] sectors;
    logic [159:0] serial; // First character in top byte
    logic [63:0] firmware;
    logic [319:0] model;
    logic [7:0] max_multi;
    logic standby_std;
    logic iordy_sup;
    logic iordy_dis;
    logic [2:0] valid_flags; // {w88, w64_70, w54_58}
    logic [15:0] cur_cylinders;
    logic [15:0] cur_heads;
    logic [15:0] cur_sectors;
    logic [31:0] capacity;
  } idr_cfg_t;

  // Task-file status bits
  typedef struct packed {
    logic busy;
    logic ready;
    logic data_req;
    logic error;
    logic aborted;
  } idr_status_t;

  localparam idr_status_t IDR_STATUS_RST = '{busy: 1'b0, ready: 1'b1, data_req: 1'b0,
                                             error: 1'b0, aborted: 1'b0};
endpackage : idr_pkg

/* File: verilog/idr_responder.sv */
// Identify data responder with its staging FIFO
`timescale 1ns/1ps

// ****************************************
// Staging FIFO
// ****************************************
module idr_fifo import idr_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH]; // Storage, no reset needed
  logic [AW:0] wr_ptr_r; // Extra bit tells full from empty
  logic [AW:0] rd_ptr_r;
  // Occupancy flags; a push or pop is only honoured when it can happen
  wire logic empty_w = (wr_ptr_r == rd_ptr_r);
  wire logic full_w = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  wire logic push_w = in_valid_i && !full_w;
  wire logic pop_w = out_ready_i && !empty_w;

  // Handshakes come from the pointers alone, so no extra flag state
  assign in_ready_o = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

  // Write side
  always_ff @(posedge ref_clk_i) begin
    if (push_w) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push_w);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop_w);
    end
  end
endmodule : idr_fifo

// ****************************************
// Responder top
// ****************************************
module idr_responder import idr_pkg::*; #(
  parameter logic [7:0] SIG_CYL_LO = 8'h00, // Packet signature, low byte
  parameter logic [7:0] SIG_CYL_HI = 8'h00 // Packet signature, high byte
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic cmd_valid_i, // Command register written
  input wire logic [7:0] cmd_code_i, // Command code
  input wire logic packet_dev_i, // Device has packet feature set
  input wire logic int_dis_i, // Interrupt disable bit
  input wire logic status_rd_i, // Host read of status clears interrupt
  input wire logic data_rd_i, // Host read of data register
  input wire idr_cfg_t cfg_i, // Identify parameters
  output idr_status_t status_o, // Task-file status
  output logic intrq_o, // Interrupt request
  output logic [15:0] data_o, // Current data word
  output logic [7:0] sig_cyl_lo_o, // Signature after abort
  output logic [7:0] sig_cyl_hi_o
);
  idr_state_t state_r; // Controller state
  idr_state_t state_nxt;
  idr_status_t status_r; // Status bits
  idr_status_t status_nxt;
  logic intrq_r; // Sticky interrupt
  logic [15:0] data_r; // Word on the data bus
  logic [8:0] wr_idx_r; // Next word to stage
  logic [8:0] rd_cnt_r; // Words read by host
  // Signature bytes presented after an abort
  logic [7:0] sig_lo_r;
  logic [7:0] sig_hi_r;

  // Force a byte into the printable range
  function automatic logic [7:0] graph_f(input logic [7:0] c);
    graph_f = (c < IDR_GRAPH_LO || c > IDR_GRAPH_HI) ? IDR_GRAPH_LO : c;
  endfunction : graph_f

  // Force both bytes of a string word printable; character 1 sits in the top byte
  function automatic logic [15:0] str_word_f(input logic [15:0] pair);
    str_word_f = {graph_f(pair[15:8]), graph_f(pair[7:0])};
  endfunction : str_word_f

  // ****************************************
  // Command decode
  // ****************************************
  // Commands while busy or mid-transfer are dropped with no error shown
  wire logic cmd_take_w = cmd_valid_i && (cmd_code_i == IDR_CMD_IDENTIFY) && !status_r.busy
                          && !status_r.data_req;
  wire logic cmd_abort_w = cmd_take_w && packet_dev_i;
  wire logic cmd_start_w = cmd_take_w && !packet_dev_i;

  // ****************************************
  // Parameter word builder
  // ****************************************
  wire logic [7:0] widx_w = wr_idx_r[7:0];
  // Offset of the current word inside each string field
  wire logic [7:0] ser_k_w = widx_w - IDR_W_SERIAL;
  wire logic [7:0] fw_k_w = widx_w - IDR_W_FW;
  wire logic [7:0] mod_k_w = widx_w - IDR_W_MODEL;
  // Field membership of the current word
  wire logic in_ser_w = widx_w >= IDR_W_SERIAL && widx_w <= IDR_W_SERIAL_END;
  wire logic in_fw_w = widx_w >= IDR_W_FW && widx_w <= IDR_W_FW_END;
  wire logic in_mod_w = widx_w >= IDR_W_MODEL && widx_w <= IDR_W_MODEL_END;
  // String words, every byte forced printable
  wire logic [15:0] ser_w = str_word_f(cfg_i.serial[159 - 16*ser_k_w -: 16]);
  wire logic [15:0] fw_w = str_word_f(cfg_i.firmware[63 - 16*fw_k_w -: 16]);
  wire logic [15:0] mod_w = str_word_f(cfg_i.model[319 - 16*mod_k_w -: 16]);
  // Flag words; bits not listed here stay zero
  wire logic [15:0] w_config_w = {8'h00, cfg_i.removable, cfg_i.fixed_dev, 3'h0,
                                  cfg_i.resp_incomplete, 2'h0};
  wire logic [15:0] w_caps_w = {2'h0, cfg_i.standby_std, 1'b0, cfg_i.iordy_sup,
                                cfg_i.iordy_dis, IDR_CAPS_ONES, 8'h00};
  logic [15:0] word_w; // Word for the current index

  // Selection of the staged word; every unlisted word is zero
  always_comb begin
    word_w = 16'h0000;
    if (in_ser_w) begin
      word_w = ser_w;
    end else if (in_fw_w) begin
      word_w = fw_w;
    end else if (in_mod_w) begin
      word_w = mod_w;
    end else begin
      case (widx_w)
        IDR_W_CONFIG: word_w = w_config_w;
        IDR_W_CYL: word_w = cfg_i.cylinders;
        IDR_W_HEADS: word_w = cfg_i.heads;
        IDR_W_SPT: word_w = cfg_i.sectors;
        IDR_W_MULTI: word_w = {IDR_MULTI_TAG, cfg_i.max_multi};
        IDR_W_CAPS: word_w = w_caps_w;
        IDR_W_CAPS2: word_w = IDR_CAPS2_VAL;
        IDR_W_VALID: word_w = {13'h0000, cfg_i.valid_flags};
        IDR_W_CUR_CYL: word_w = cfg_i.cur_cylinders;
        IDR_W_CUR_HEADS: word_w = cfg_i.cur_heads;
        IDR_W_CUR_SPT: word_w = cfg_i.cur_sectors;
        IDR_W_CAP_LO: word_w = cfg_i.capacity[15:0];
        IDR_W_CAP_HI: word_w = cfg_i.capacity[31:16];
        default: word_w = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Staging FIFO and its handshakes
  // ****************************************
  wire logic fill_w = (state_r != IDR_IDLE) && (wr_idx_r != IDR_WORD_END);
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  // Block is ready once the FIFO is full or holds the whole tail
  wire logic staged_w = fifo_out_valid && (!fifo_in_ready || !fill_w);
  wire logic go_xfer_w = (state_r == IDR_PREP) && staged_w;
  wire logic host_rd_w = (state_r == IDR_XFER) && data_rd_i;
  wire logic last_rd_w = host_rd_w && (rd_cnt_r == IDR_LAST_WORD);
  // Fill runs one word per cycle ahead of reads, so the head is always there
  wire logic pop_w = go_xfer_w || (host_rd_w && !last_rd_w);

  // Staging ahead of the host costs sixteen words of storage, but lets
  // the word builder run without regard to the host's read timing
  idr_fifo #(
    .WIDTH(IDR_FIFO_WIDTH),
    .DEPTH(IDR_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(fill_w),
    .in_ready_o(fifo_in_ready),
    .in_data_i(word_w),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop_w),
    .out_data_o(fifo_out_data)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state and status; busy and request flip in one step
  always_comb begin
    state_nxt = state_r;
    status_nxt = status_r;
    case (state_r)
      IDR_IDLE: begin
        if (cmd_abort_w) begin
          status_nxt = '{busy: 1'b0, ready: 1'b1, data_req: 1'b0, error: 1'b1,
                         aborted: 1'b1};
        end else if (cmd_start_w) begin
          state_nxt = IDR_PREP;
          status_nxt = '{busy: 1'b1, ready: 1'b1, data_req: 1'b0, error: 1'b0,
                         aborted: 1'b0};
        end
      end
      IDR_PREP: begin
        if (go_xfer_w) begin
          state_nxt = IDR_XFER;
          status_nxt.busy = 1'b0;
          status_nxt.data_req = 1'b1;
        end
      end
      IDR_XFER: begin
        if (last_rd_w) begin
          state_nxt = IDR_IDLE;
          status_nxt = IDR_STATUS_RST;
        end
      end
      default: begin
        state_nxt = IDR_IDLE;
        status_nxt = IDR_STATUS_RST;
      end
    endcase
  end

  // Interrupt raise events; raising wins over a clearing status read
  wire logic irq_evt_w = (go_xfer_w || cmd_abort_w) && !int_dis_i;
  wire logic irq_nxt_w = irq_evt_w || (intrq_r && !status_rd_i && !cmd_take_w);

  // State, status and interrupt registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= IDR_IDLE;
      status_r <= IDR_STATUS_RST;
      intrq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      status_r <= status_nxt;
      intrq_r <= irq_nxt_w;
    end
  end

  // Word counters; both restart with each identify that starts a transfer, not on an abort
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_idx_r <= '0;
      rd_cnt_r <= '0;
    end else begin
      wr_idx_r <= cmd_start_w ? 9'h000 : wr_idx_r + 9'(fill_w && fifo_in_ready);
      rd_cnt_r <= cmd_start_w ? 9'h000 : rd_cnt_r + 9'(host_rd_w);
    end
  end

  // Data word and signature registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_r <= IDR_DATA_RST;
      sig_lo_r <= 8'h00;
      sig_hi_r <= 8'h00;
    end else begin
      if (pop_w) begin
        data_r <= fifo_out_data;
        // Bus returns to zero once the last word has gone
      end else if (last_rd_w) begin
        data_r <= IDR_DATA_RST;
      end
      if (cmd_abort_w) begin
        sig_lo_r <= SIG_CYL_LO;
        sig_hi_r <= SIG_CYL_HI;
      end
    end
  end

  // Top outputs come straight from registers
  assign status_o = status_r;
  assign intrq_o = intrq_r;
  assign data_o = data_r;
  assign sig_cyl_lo_o = sig_lo_r;
  assign sig_cyl_hi_o = sig_hi_r;
endmodule : idr_responder
